// File: pkg/ccod_pkg.sv
`default_nettype none
// shared constants and types for the clock output driver control block
package ccod_pkg;

  // fixed structure
  localparam int NCH    = 4;                 // number of output drivers
  localparam int CFG_W  = 16;                // stored width of a driver config word
  localparam int DIV_W  = 8;                 // half-period count width
  localparam int FREQ_W = 20;                // selected input frequency, in kHz
  localparam int AW     = 8;                 // register address width
  localparam int DW     = 32;                // register data width

  // register byte offsets
  localparam logic [7:0] OFS_CFG0   = 8'h00; // driver config, one word per driver
  localparam logic [7:0] OFS_DIV0   = 8'h10; // output divider half period
  localparam logic [7:0] OFS_PHASE0 = 8'h20; // phase step request, write only
  localparam logic [7:0] OFS_GCTRL  = 8'h30; // global control
  localparam logic [7:0] OFS_FREQ   = 8'h34; // selected input frequency in kHz
  localparam logic [7:0] OFS_STATUS = 8'h38; // status, read only

  // driver config field positions
  localparam int B_EN     = 0;               // register enable of the driver
  localparam int B_DISHI  = 1;               // disabled level: 1 high, 0 low
  localparam int B_SYNC   = 2;               // synchronous disable
  localparam int B_SE     = 3;               // single-ended mode
  localparam int B_INVT   = 4;               // invert true pin
  localparam int B_INVC   = 5;               // invert complement pin
  localparam int B_DRV_LO = 6;               // drive strength code, two bits
  localparam int B_PD     = 8;               // power down

  // global control and status field positions
  localparam int B_ZDM      = 0;             // zero delay mode request
  localparam int B_ST_INIT  = 0;             // configuration loaded
  localparam int B_ST_ZDM   = 1;             // zero delay mode active
  localparam int B_ST_HITL  = 2;             // hitless switching allowed
  localparam int B_ST_GLOB  = 3;             // global pin permits outputs
  localparam int B_ST_ACT   = 8;             // per-driver active flags start here

  // drive strength codes
  localparam logic [1:0] DRV_WEAK   = 2'h1;
  localparam logic [1:0] DRV_MEDIUM = 2'h2;
  localparam logic [1:0] DRV_STRONG = 2'h3;

  // values after reset and limits
  localparam logic [CFG_W-1:0]  CFG_RST     = 16'h0000;
  localparam logic [DIV_W-1:0]  DIV_RST     = 8'h00;
  localparam logic [FREQ_W-1:0] FREQ_RST    = 20'h0_0000;
  localparam logic [FREQ_W-1:0] ZDM_MIN_KHZ = 20'h0_0080;  // 128 kHz
  localparam logic [3:0]        NVM_WORDS   = 4'h8;        // configs, then dividers

  // configuration load sequencer
  typedef enum logic [1:0] {st_idle, st_load, st_run} ccod_state_t;

endpackage : ccod_pkg
`default_nettype wire

// File: src/ccod_sync.sv
`default_nettype none
// two flip-flop synchroniser for a level from outside the clock domain
module ccod_sync
  import ccod_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic ff1;  // first stage, read only by the second
    logic ff2;  // settled copy
  } ccod_sync_t;

  ccod_sync_t s_reg;
  ccod_sync_t s_next;

  // shift the level through both stages
  always_comb begin
    s_next     = s_reg;
    s_next.ff1 = d;
    s_next.ff2 = s_reg.ff1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.ff2;

endmodule : ccod_sync
`default_nettype wire

// File: src/ccod_chan.sv
`default_nettype none
// one output driver: divider, phase stepping, gating, polarity
module ccod_chan
  import ccod_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             div_rst,
  input  wire logic [DIV_W-1:0] half,
  input  wire logic             phase_wr,
  input  wire logic [DIV_W-1:0] phase_val,
  input  wire logic             en_req,
  input  wire logic             sync_dis,
  input  wire logic             dis_high,
  input  wire logic             single_ended,
  input  wire logic             inv_true,
  input  wire logic             inv_comp,
  input  wire logic             power_down,
  output logic                  clock_pin_true,
  output logic                  clock_pin_complement,
  output logic                  active,
  output logic                  raw_clk
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;   // cycles left in this half period
    logic             clk;   // raw divided clock
    logic [DIV_W-1:0] pend;  // phase delay cycles still to insert
    logic             gate;  // driver passing the clock
    logic             out_t; // true pin level
    logic             out_c; // complement pin level
  } ccod_chan_t;

  ccod_chan_t s_reg;
  ccod_chan_t s_next;
  logic       rise;         // raw clock about to rise: a period has ended
  logic [DIV_W-1:0] base;   // pending delay after this cycle's use

  // divider, delay insertion, gating and pin levels
  always_comb begin
    s_next = s_reg;
    base   = s_reg.pend;
    rise   = (s_reg.cnt == DIV_RST) && !s_reg.clk && (s_reg.pend == DIV_RST);
    if (div_rst || power_down) begin
      // known divider state; a reset also drops any pending skew
      s_next.cnt = DIV_RST;
      s_next.clk = 1'b0;
      if (div_rst) begin
        base = DIV_RST;
      end
    end else if (s_reg.cnt != DIV_RST) begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end else if (!s_reg.clk && (s_reg.pend != DIV_RST)) begin
      // stretch the low half only, so no pulse ever gets shorter
      base = s_reg.pend - 8'h01;
    end else begin
      s_next.clk = !s_reg.clk;
      s_next.cnt = half;
    end
    s_next.pend = phase_wr ? (base + phase_val) : base;
    // gating: immediate, or only at the end of a whole period
    if (power_down || div_rst) begin
      s_next.gate = 1'b0;
    end else if (!sync_dis) begin
      s_next.gate = en_req;
    end else if (rise) begin
      s_next.gate = en_req;
    end
    // pin levels follow the next gate and clock, so they stay in step
    s_next.out_t = s_next.gate ? (s_next.clk ^ inv_true) : dis_high;
    if (single_ended) begin
      s_next.out_c = s_next.gate ? (s_next.clk ^ inv_comp) : dis_high;
    end else begin
      s_next.out_c = !s_next.out_t;
    end
    if (power_down) begin
      s_next.out_t = 1'b0;
      s_next.out_c = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clock_pin_true       = s_reg.out_t;
  assign clock_pin_complement = s_reg.out_c;
  assign active               = s_reg.gate;
  assign raw_clk              = s_reg.clk;

  property p_imm_off;
    @(posedge clk_sys) disable iff (rst) (!en_req && !sync_dis) |=> !active;
  endproperty
  a_imm_off: assert property (p_imm_off) else $error("driver did not stop at once");

  property p_sync_hold;
    @(posedge clk_sys) disable iff (rst)
      (active && s_reg.clk && sync_dis && !div_rst && !power_down) |=> active;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("driver cut mid period");

  property p_dis_level;
    @(posedge clk_sys) disable iff (rst)
      (!active && !$past(power_down)) |-> (clock_pin_true == $past(dis_high));
  endproperty
  a_dis_level: assert property (p_dis_level) else $error("wrong disabled level");

  property p_in_phase;
    @(posedge clk_sys) disable iff (rst)
      (active && $past(single_ended) && !$past(inv_true) && !$past(inv_comp)
       && !$past(power_down)) |-> (clock_pin_true == clock_pin_complement);
  endproperty
  a_in_phase: assert property (p_in_phase) else $error("single-ended pins not in phase");

  property p_delay_low;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.cnt == DIV_RST && !s_reg.clk && s_reg.pend != DIV_RST && !div_rst
       && !power_down) |=> !raw_clk;
  endproperty
  a_delay_low: assert property (p_delay_low) else $error("phase step shortened a pulse");

  property p_div_reset;
    @(posedge clk_sys) disable iff (rst) div_rst |=> (!raw_clk && !active);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not held in reset");

endmodule : ccod_chan
`default_nettype wire

// File: src/ccod_top.sv
`default_nettype none
// How it works
// - pin high forces every driver disabled
// - pin low enables drivers per register
// - each driver has own register disable
// - disabled driver rests low or high
// - sync disable waits for period end
// - without sync, disable stops clock immediately
// - single-ended: both pins clock, in phase
// - per-pin polarity inversion in single-ended; differential uses only the true-pin inversion, and the complement follows it
// - drive strength codes one to three
// - phase steps applied glitchlessly while running
// - zero delay uses external feedback, above 128kHz
// - no hitless switching in zero delay
// - dividers reset during power-up initialisation
// - unused drivers can be powered down
// - defaults load from memory before clocks
module ccod_top
  import ccod_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // register port
  input  wire logic [AW-1:0]    reg_addr,
  input  wire logic [DW-1:0]    reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [DW-1:0]    reg_rdata,
  // pins
  input  wire logic             global_output_disable_pin,
  input  wire logic             external_feedback_input,
  // configuration memory, data one cycle after the address
  output logic      [2:0]       nvm_addr,
  output logic                  nvm_rd,
  input  wire logic [DW-1:0]    nvm_data,
  // drivers
  output logic      [NCH-1:0]   clock_pin_true,
  output logic      [NCH-1:0]   clock_pin_complement,
  output logic      [NCH-1:0]   drive_select_weak,
  output logic      [NCH-1:0]   drive_select_medium,
  output logic      [NCH-1:0]   drive_select_strong,
  output logic      [NCH-1:0]   driver_power_down,
  // loop and status
  output logic                  feedback_clock,
  output logic                  zero_delay_active,
  output logic                  hitless_switch_allowed,
  output logic                  init_done
);

  typedef struct packed {
    ccod_state_t                   state;    // load sequencer
    logic [3:0]                    idx;      // next memory word to ask for
    logic                          cap;      // a memory word arrives this cycle
    logic [NCH-1:0][CFG_W-1:0]     cfg;      // driver config words
    logic [NCH-1:0][DIV_W-1:0]     div;      // divider half periods
    logic                          zdm_req;  // zero delay mode requested
    logic [FREQ_W-1:0]             freq_khz; // selected input frequency
    logic [NCH-1:0]                phase_wr; // one-cycle phase step pulses
    logic [DIV_W-1:0]              phase_val;// size of the phase step
    logic [DW-1:0]                 rdata;    // read answer
  } ccod_top_t;

  ccod_top_t        s_reg;
  ccod_top_t        s_next;
  logic             glob_dis_s;   // synchronised global pin
  logic             ext_fb_s;     // synchronised feedback input
  logic [NCH-1:0]   chan_en;      // per-driver enable request
  logic [NCH-1:0]   chan_act;     // per-driver active flags
  logic [NCH-1:0]   chan_raw;     // raw divided clocks
  logic             running;      // configuration loaded
  logic             zdm_ok;       // zero delay allowed and requested
  logic [7:0]       base;         // register region of the address
  logic [1:0]       ch;           // driver index of the address
  logic             lane_ok;      // word aligned access
  logic [3:0]       cidx;         // index of the memory word arriving

  // the pin comes from outside, so it is settled before use
  ccod_sync u_sync_oe (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (global_output_disable_pin),
    .q       (glob_dis_s)
  );

  // the feedback input is a foreign clock and is treated as a level
  ccod_sync u_sync_fb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (external_feedback_input),
    .q       (ext_fb_s)
  );

  assign running = (s_reg.state == st_run);
  // frequency check guards against a loop that cannot lock externally
  assign zdm_ok  = running && s_reg.zdm_req && (s_reg.freq_khz > ZDM_MIN_KHZ);

  // address split; the low two bits must be zero
  assign base    = {reg_addr[7:4], 4'h0};
  assign ch      = reg_addr[3:2];
  assign lane_ok = (reg_addr[1:0] == 2'h0);
  assign cidx    = s_reg.idx - 4'h1;

  // register port, configuration load and sequencer
  always_comb begin
    s_next          = s_reg;
    s_next.phase_wr = '0;
    s_next.rdata    = '0;
    unique case (s_reg.state)
      st_idle: begin
        // start the memory walk right after reset
        s_next.state = st_load;
        s_next.idx   = 4'h0;
        s_next.cap   = 1'b0;
      end
      st_load: begin
        // capture the word asked for one cycle ago
        if (s_reg.cap) begin
          if (!cidx[2]) begin
            s_next.cfg[cidx[1:0]] = nvm_data[CFG_W-1:0];
          end else begin
            s_next.div[cidx[1:0]] = nvm_data[DIV_W-1:0];
          end
        end
        s_next.cap = (s_reg.idx < NVM_WORDS);
        if (s_reg.idx < NVM_WORDS) begin
          s_next.idx = s_reg.idx + 4'h1;
        end else if (!s_reg.cap) begin
          s_next.state = st_run;
        end
      end
      st_run: begin
        // software writes only once the defaults are in place
        if (reg_wr && lane_ok) begin
          if (base == OFS_CFG0) begin
            s_next.cfg[ch] = reg_wdata[CFG_W-1:0];
          end else if (base == OFS_DIV0) begin
            s_next.div[ch] = reg_wdata[DIV_W-1:0];
          end else if (base == OFS_PHASE0) begin
            s_next.phase_wr[ch] = 1'b1;
            s_next.phase_val    = reg_wdata[DIV_W-1:0];
          end else if (reg_addr == OFS_GCTRL) begin
            s_next.zdm_req = reg_wdata[B_ZDM];
          end else if (reg_addr == OFS_FREQ) begin
            s_next.freq_khz = reg_wdata[FREQ_W-1:0];
          end
        end
      end
      default: begin
        // the spare state code restarts the load
        s_next.state = st_idle;
      end
    endcase
    // reads answer in every state; unmapped words read zero
    if (reg_rd && lane_ok) begin
      if (base == OFS_CFG0) begin
        s_next.rdata[CFG_W-1:0] = s_reg.cfg[ch];
      end else if (base == OFS_DIV0) begin
        s_next.rdata[DIV_W-1:0] = s_reg.div[ch];
      end else if (reg_addr == OFS_GCTRL) begin
        s_next.rdata[B_ZDM] = s_reg.zdm_req;
      end else if (reg_addr == OFS_FREQ) begin
        s_next.rdata[FREQ_W-1:0] = s_reg.freq_khz;
      end else if (reg_addr == OFS_STATUS) begin
        s_next.rdata[B_ST_INIT]            = running;
        s_next.rdata[B_ST_ZDM]             = zdm_ok;
        s_next.rdata[B_ST_HITL]            = !zdm_ok;
        s_next.rdata[B_ST_GLOB]            = !glob_dis_s;
        s_next.rdata[B_ST_ACT +: NCH]      = chan_act;
      end
    end
  end

  // every register runs every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg           <= '0;
      s_reg.state     <= st_idle;
      s_reg.cfg       <= {NCH{CFG_RST}};
      s_reg.div       <= {NCH{DIV_RST}};
      s_reg.freq_khz  <= FREQ_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // one driver per output, each gated by pin, register and load state
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    // pin low plus register enable; nothing before defaults load
    assign chan_en[g] = running && !glob_dis_s && s_reg.cfg[g][B_EN]
                        && !s_reg.cfg[g][B_PD];
    // the drive code picks one impedance; a zero code falls back to weak
    assign drive_select_weak[g]   = (s_reg.cfg[g][B_DRV_LO +: 2] == DRV_WEAK)
                                    || (s_reg.cfg[g][B_DRV_LO +: 2] == 2'h0);
    assign drive_select_medium[g] = (s_reg.cfg[g][B_DRV_LO +: 2] == DRV_MEDIUM);
    assign drive_select_strong[g] = (s_reg.cfg[g][B_DRV_LO +: 2] == DRV_STRONG);
    assign driver_power_down[g]   = s_reg.cfg[g][B_PD];

    ccod_chan u_chan (
      .clk_sys              (clk_sys),
      .rst                  (rst),
      .div_rst              (!running),
      .half                 (s_reg.div[g]),
      .phase_wr             (s_reg.phase_wr[g]),
      .phase_val            (s_reg.phase_val),
      .en_req               (chan_en[g]),
      .sync_dis             (s_reg.cfg[g][B_SYNC]),
      .dis_high             (s_reg.cfg[g][B_DISHI]),
      .single_ended         (s_reg.cfg[g][B_SE]),
      .inv_true             (s_reg.cfg[g][B_INVT]),
      .inv_comp             (s_reg.cfg[g][B_INVC]),
      .power_down           (s_reg.cfg[g][B_PD]),
      .clock_pin_true       (clock_pin_true[g]),
      .clock_pin_complement (clock_pin_complement[g]),
      .active               (chan_act[g]),
      .raw_clk              (chan_raw[g])
    );
  end

  // zero delay closes the loop outside; otherwise driver 0 feeds back
  assign feedback_clock         = zdm_ok ? ext_fb_s : chan_raw[0];
  assign zero_delay_active      = zdm_ok;
  // hitless switching cannot coexist with an external loop
  assign hitless_switch_allowed = !zdm_ok;
  assign init_done              = running;
  assign nvm_addr               = s_reg.idx[2:0];
  assign nvm_rd                 = (s_reg.state == st_load) && (s_reg.idx < NVM_WORDS);
  assign reg_rdata              = s_reg.rdata;

  property p_glob_off;
    @(posedge clk_sys) disable iff (rst)
      global_output_disable_pin [*3] |-> (chan_en == '0);
  endproperty
  a_glob_off: assert property (p_glob_off) else $error("pin high left a driver on");

  property p_glob_on;
    @(posedge clk_sys) disable iff (rst)
      (!global_output_disable_pin [*3] ##0 (running && s_reg.cfg[0][B_EN]
       && !s_reg.cfg[0][B_PD])) |-> chan_en[0];
  endproperty
  a_glob_on: assert property (p_glob_on) else $error("pin low did not enable");

  property p_reg_dis;
    @(posedge clk_sys) disable iff (rst)
      (running && !s_reg.cfg[1][B_EN]) |-> !chan_en[1];
  endproperty
  a_reg_dis: assert property (p_reg_dis) else $error("register disable ignored");

  property p_enable_and;
    @(posedge clk_sys) disable iff (rst)
      chan_en[0] |-> (!glob_dis_s && s_reg.cfg[0][B_EN] && running);
  endproperty
  a_enable_and: assert property (p_enable_and) else $error("enable without both permits");

  property p_zdm_freq;
    @(posedge clk_sys) disable iff (rst)
      zero_delay_active |-> (s_reg.freq_khz > ZDM_MIN_KHZ && s_reg.zdm_req);
  endproperty
  a_zdm_freq: assert property (p_zdm_freq) else $error("zero delay below 128 kHz");

  property p_no_hitless;
    @(posedge clk_sys) disable iff (rst)
      zero_delay_active |-> !hitless_switch_allowed;
  endproperty
  a_no_hitless: assert property (p_no_hitless) else $error("hitless allowed in zero delay");

  property p_load_first;
    @(posedge clk_sys) disable iff (rst) !init_done |=> (chan_act == '0);
  endproperty
  a_load_first: assert property (p_load_first) else $error("clock before defaults loaded");

  property p_drive;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.cfg[2][B_DRV_LO +: 2] == DRV_STRONG) |->
        (drive_select_strong[2] && !drive_select_weak[2] && !drive_select_medium[2]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive code not decoded");

  property p_pdown;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.cfg[3][B_PD] && $past(s_reg.cfg[3][B_PD])) |->
        (!clock_pin_true[3] && !clock_pin_complement[3] && driver_power_down[3]);
  endproperty
  a_pdown: assert property (p_pdown) else $error("powered-down driver toggles");

endmodule : ccod_top
`default_nettype wire

// File: test/ccod_rx_model.sv
`default_nettype none
// far side: configuration memory plus a receiver counting rising clock edges
module ccod_rx_model
  import ccod_pkg::*;
(
  input  wire logic [0:0]     clk_sys,
  input  wire logic [2:0]     nvm_addr,
  input  wire logic           nvm_rd,
  output logic      [DW-1:0]  nvm_data,
  input  wire logic [NCH-1:0] clock_pin_true,
  output int                  edges [NCH]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NCH-1:0] prev = '0;  // last seen pin levels
  initial nvm_data = '0;
  initial foreach (edges[i]) edges[i] = 0;
  // defaults: drivers enabled and differential, half period of four cycles
  function automatic logic [DW-1:0] word(input logic [2:0] a);
    return a[2] ? 32'h0000_0003 : 32'h0000_0001;
  endfunction : word
  // data the cycle after the address; lines are not held outside a read
  always @(posedge clk_sys) begin
    nvm_data <= nvm_rd ? word(nvm_addr) : ~nvm_data;
    prev <= clock_pin_true;
    foreach (edges[i]) if (clock_pin_true[i] && !prev[i]) edges[i]++;
  end
endmodule : ccod_rx_model
`default_nettype wire

// File: test/clock_output_driver_control_tb_top.sv
`default_nettype none
// bench: register traffic and driver pins against a small model of the configs
module clock_output_driver_control_tb_top;
  import ccod_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, pin = 0, fb = 0;
  logic           nvm_rd, zda, hit, fbk, idone, pv;
  logic [AW-1:0]  reg_addr = '0;
  logic [DW-1:0]  reg_wdata = '0, reg_rdata, nvm_data, rv;
  logic [2:0]     nvm_addr;
  logic [NCH-1:0] pt, pc, dw, dm, ds, pd;
  logic [15:0]    cfg_m [NCH];  // model of the stored driver configs
  logic [15:0]    c;
  int             edges [NCH];
  int             fail_count = 0, checks = 0, cyc = 0, e0, run, nch;
  // table of awkward configs: weak/medium/strong, inversions, levels, power down, sync
  logic [15:0] tab [10] = '{16'h0041, 16'h0089, 16'h00D9, 16'h00E9, 16'h0002,
                            16'h0000, 16'h000A, 16'h0101, 16'h0005, 16'h0003};

  ccod_top ccod_top_inst (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .global_output_disable_pin(pin), .external_feedback_input(fb), .nvm_addr, .nvm_rd,
    .nvm_data, .clock_pin_true(pt), .clock_pin_complement(pc), .drive_select_weak(dw),
    .drive_select_medium(dm), .drive_select_strong(ds), .driver_power_down(pd),
    .feedback_clock(fbk), .zero_delay_active(zda), .hitless_switch_allowed(hit),
    .init_done(idone));
  ccod_rx_model ccod_rx_model_inst (.clk_sys, .nvm_addr, .nvm_rd, .nvm_data,
    .clock_pin_true(pt), .edges);

  initial forever #12.5 clk_sys = ~clk_sys;
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(string what, logic [DW-1:0] seen, logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle strobes; the edge after release is never reused for a new strobe
  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
    #1;
  endtask : wr

  task automatic rd(logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask : rd

  // sync-off gating must settle within four cycles, sync-on within 20 cycles
  task automatic check_ch(int n);
    logic [15:0] k;
    k = cfg_m[n];
    repeat (k[B_SYNC] ? 20 : 4) @(posedge clk_sys);
    #1;
    chk("drive", {ds[n], dm[n], dw[n]}, k[7:6] == 3 ? 3'b100 : k[7:6] == 2 ? 3'b010 : 3'b001);
    chk("pwr", pd[n], k[B_PD]);
    if (k[B_PD]) chk("pd pins", {pt[n], pc[n]}, 2'b00);
    else if (pin || !k[B_EN]) chk("idle", {pt[n], pc[n]}, {k[1], k[1] ^ !k[B_SE]});
    else begin
      e0 = edges[n];
      repeat (16) @(posedge clk_sys);
      #1;
      chk("edges", edges[n] - e0, 2);
      chk("pair", pc[n], k[B_SE] ? pt[n] ^ k[B_INVT] ^ k[B_INVC] : !pt[n]);
    end
  endtask : check_ch

  initial begin
    void'($urandom(32'hA651_A8AF));
    foreach (cfg_m[i]) cfg_m[i] = 16'h0001;
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    for (int i = 0; i < 40 && idone !== 1'b1; i++) @(posedge clk_sys);
    chk("init", idone, 1);
    for (int i = 0; i < NCH; i++) begin
      rd(OFS_CFG0 + 8'(4 * i), rv);
      chk("cfg dflt", rv, 1);
      rd(OFS_DIV0 + 8'(4 * i), rv);
      chk("div dflt", rv, 3);
    end
    rd(OFS_STATUS, rv);
    chk("status", rv[11:0], 12'hF0D);
    for (int k = 0; k < 16; k++) begin
      c = k < 10 ? tab[k] : 16'($urandom % 512);
      @(posedge clk_sys);
      pin <= (k == 9) || (k > 9 && $urandom % 4 == 0);
      wr(OFS_CFG0 + 8'(4 * (k % 4)), {16'h0, c});
      cfg_m[k % 4] = c;
      check_ch(k % 4);
    end
    @(posedge clk_sys);
    pin <= 0;
    wr(OFS_CFG0, 1);
    wr(OFS_PHASE0, 3);
    nch = 0;
    run = 0;
    pv = pt[0];
    // every half period seen while the phase steps in stays full length
    repeat (80) begin
      @(posedge clk_sys);
      #1 run++;
      if (pt[0] !== pv) begin
        if (nch++ > 0) chk("glitch", run >= 4, 1);
        run = 0;
        pv = pt[0];
      end
    end
    wr(OFS_GCTRL, 1);
    wr(OFS_FREQ, 128);
    chk("zd at 128", {zda, hit}, 2'b01);
    wr(OFS_FREQ, 129);
    chk("zd above", {zda, hit}, 2'b10);
    @(posedge clk_sys);
    fb <= 1;
    repeat (4) @(posedge clk_sys);
    #1 chk("fb", fbk, 1);
    wr(8'h3C, '1);
    rd(8'h3C, rv);
    chk("unmapped", rv, 0);
    close_out();
  end
endmodule : clock_output_driver_control_tb_top
`default_nettype wire
